// ---- lineif_pins.sv ----
// System-side pin logic: recovered clock mux, serial loss output, tx capture
`timescale 1ns/1ns
module lineif_pins
    import lineif_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    output logic                     irq,
    input  wire logic [NCH-1:0]      line_clock,
    input  wire logic [NCH-1:0]      line_loss,
    input  wire logic [NCH-1:0]      rx_pos_in,
    input  wire logic [NCH-1:0]      rx_neg_in,
    input  wire logic [NCH-1:0]      rx_mf_in,
    input  wire logic                reference_clock,
    output logic      [NCH-1:0]      recovered_rx_clock,
    output logic      [NCH-1:0]      rx_positive_rail_data,
    output logic      [NCH-1:0]      rx_negative_rail_data,
    output logic                     status_clock_out,
    output logic                     serial_line_signal_loss,
    output logic                     serial_line_signal_loss_oe,
    output logic                     first_channel_slot_marker,
    output logic                     first_channel_slot_marker_oe,
    input  wire logic [NCH-1:0]      tx_clock_in,
    input  wire logic [NCH-1:0]      tx_positive_rail_data,
    input  wire logic [NCH-1:0]      tx_negative_rail_data,
    output logic      [NCH-1:0]      tx_pos_sampled,
    output logic      [NCH-1:0]      tx_neg_sampled
);
    import lineif_pkg::*;

    // ------------------------------------------------------------------
    // APB registers
    // ------------------------------------------------------------------
    logic [7:0]     rx_config_reg_a_reg, rx_config_reg_a_next;
    logic [7:0]     rx_config_reg_b_reg, rx_config_reg_b_next;
    logic [7:0]     tx_config_reg_b_reg, tx_config_reg_b_next;
    logic [7:0]     stat_cfg_reg, stat_cfg_next;
    logic [NCH-1:0] int_stat_reg, int_stat_next;
    logic [NCH-1:0] int_mask_reg, int_mask_next;
    logic [NCH-1:0] loss_prev_reg, loss_prev_next;
    logic           wr_en;
    logic           rd_hit;

    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_comb begin
        rx_config_reg_a_next = rx_config_reg_a_reg;
        rx_config_reg_b_next = rx_config_reg_b_reg;
        tx_config_reg_b_next = tx_config_reg_b_reg;
        stat_cfg_next        = stat_cfg_reg;
        int_mask_next        = int_mask_reg;
        int_stat_next        = int_stat_reg;
        loss_prev_next       = line_loss;
        if (wr_en) begin
            unique case (paddr)
                RX_CFG_A_ADDR: rx_config_reg_a_next = pwdata[7:0];
                RX_CFG_B_ADDR: rx_config_reg_b_next = pwdata[7:0];
                TX_CFG_B_ADDR: tx_config_reg_b_next = pwdata[7:0];
                STAT_CFG_ADDR: stat_cfg_next        = pwdata[7:0];
                INT_MASK_ADDR: int_mask_next        = pwdata[NCH-1:0];
                INT_STAT_ADDR: int_stat_next = int_stat_reg & ~pwdata[NCH-1:0];
                default: ;
            endcase
        end
        // Set wins over clear: new loss events
        int_stat_next = int_stat_next | (line_loss & ~loss_prev_reg);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_config_reg_a_reg <= RX_CFG_A_RST;
            rx_config_reg_b_reg <= RX_CFG_B_RST;
            tx_config_reg_b_reg <= TX_CFG_B_RST;
            stat_cfg_reg        <= STAT_CFG_RST;
            int_mask_reg        <= '0;
            int_stat_reg        <= '0;
            loss_prev_reg       <= '0;
        end else begin
            rx_config_reg_a_reg <= rx_config_reg_a_next;
            rx_config_reg_b_reg <= rx_config_reg_b_next;
            tx_config_reg_b_reg <= tx_config_reg_b_next;
            stat_cfg_reg        <= stat_cfg_next;
            int_mask_reg        <= int_mask_next;
            int_stat_reg        <= int_stat_next;
            loss_prev_reg       <= loss_prev_next;
        end
    end

    assign irq = |(int_stat_reg & int_mask_reg);

    always_comb begin
        prdata = ZERO_WORD;
        rd_hit = psel && !pwrite;
        if (rd_hit) begin
            unique case (paddr)
                RX_CFG_A_ADDR: prdata = {24'h000000, rx_config_reg_a_reg};
                RX_CFG_B_ADDR: prdata = {24'h000000, rx_config_reg_b_reg};
                TX_CFG_B_ADDR: prdata = {24'h000000, tx_config_reg_b_reg};
                STAT_CFG_ADDR: prdata = {24'h000000, stat_cfg_reg};
                LOS_STAT_ADDR: prdata = {15'h0000, line_loss};
                INT_STAT_ADDR: prdata = {15'h0000, int_stat_reg};
                INT_MASK_ADDR: prdata = {15'h0000, int_mask_reg};
                default:       prdata = ZERO_WORD;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Configuration decode
    // ------------------------------------------------------------------
    logic [1:0] rx_mode;
    logic [1:0] tx_mode;
    logic       rx_clock_edge_select;
    logic       rx_clock_loss_behaviour;
    logic       tx_data_invert;
    logic       stat_en;
    logic       stat_fast;

    assign rx_mode                 = rx_config_reg_b_reg[MODE_LSB +: 2];
    assign tx_mode                 = tx_config_reg_b_reg[MODE_LSB +: 2];
    assign rx_clock_edge_select    = rx_config_reg_b_reg[RX_EDGE_SEL_BIT];
    assign rx_clock_loss_behaviour = rx_config_reg_a_reg[RX_LOSS_BEHAV_BIT];
    assign tx_data_invert          = tx_config_reg_b_reg[TX_INVERT_BIT];
    assign stat_en                 = stat_cfg_reg[STAT_EN_BIT];
    assign stat_fast               = stat_cfg_reg[STAT_RATE_BIT];

    // ------------------------------------------------------------------
    // Per-channel receive and transmit pins
    // ------------------------------------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            logic rx_p_reg, rx_n_reg;
            logic tx_p_reg, tx_n_reg;
            logic rx_edge;
            logic rck;

            // Line clock is 1.544 or 2.048 MHz from the recovery path
            assign rx_edge = line_clock[ch] ^ rx_clock_edge_select;

            always_ff @(posedge rx_edge or negedge presetn) begin
                if (!presetn) begin
                    rx_p_reg <= 1'b0;
                    rx_n_reg <= 1'b0;
                end else begin
                    rx_p_reg <= rx_pos_in[ch];
                    rx_n_reg <= (rx_mode == MODE_SR_NRZ) ? rx_mf_in[ch]
                                                         : rx_neg_in[ch];
                end
            end

            always_comb begin
                if (!line_loss[ch]) begin
                    rck = line_clock[ch];
                end else if (rx_clock_loss_behaviour) begin
                    rck = reference_clock;
                end else begin
                    rck = 1'b1;
                end
            end

            // Sliced mode: pin carries multifunction output
            assign recovered_rx_clock[ch] = (rx_mode == MODE_SLICED)
                                          ? rx_mf_in[ch] : rck;
            assign rx_positive_rail_data[ch] = (rx_mode == MODE_SLICED)
                                             ? rx_pos_in[ch] : rx_p_reg;
            assign rx_negative_rail_data[ch] = (rx_mode == MODE_SLICED)
                                             ? rx_neg_in[ch] : rx_n_reg;

            always_ff @(posedge tx_clock_in[ch] or negedge presetn) begin
                if (!presetn) begin
                    tx_p_reg <= 1'b0;
                    tx_n_reg <= 1'b0;
                end else begin
                    // Shared pin is positive rail in dual modes
                    tx_p_reg <= tx_positive_rail_data[ch]
                              ^ tx_data_invert;
                    tx_n_reg <= (tx_mode == MODE_SR_NRZ) ? 1'b0
                              : tx_negative_rail_data[ch]
                              ^ tx_data_invert;
                end
            end

            assign tx_pos_sampled[ch] = tx_p_reg;
            assign tx_neg_sampled[ch] = tx_n_reg;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Status clock and serial loss frame
    // ------------------------------------------------------------------
    logic [11:0]   div_reg, div_next;
    logic          sclk_reg, sclk_next;
    logic [CW-1:0] slot_reg, slot_next;
    logic          los_reg, los_next;
    logic          mark_reg, mark_next;
    logic [11:0]   half;
    logic          rise;

    assign half = stat_fast ? FAST_HALF : SLOW_HALF;
    assign rise = stat_en && !sclk_reg && (div_reg >= half - 12'h001);

    always_comb begin
        div_next  = div_reg;
        sclk_next = sclk_reg;
        slot_next = slot_reg;
        los_next  = los_reg;
        mark_next = mark_reg;
        if (!stat_en) begin
            div_next  = '0;
            sclk_next = 1'b0;
            slot_next = '0;
            mark_next = 1'b0;
            los_next  = 1'b0;
        end else if (div_reg >= half - 12'h001) begin
            div_next  = '0;
            sclk_next = !sclk_reg;
            if (rise) begin
                los_next  = line_loss[slot_reg];
                mark_next = (slot_reg == '0);
                slot_next = (slot_reg == LAST_SLOT) ? '0
                          : slot_reg + CW'(1);
            end
        end else begin
            div_next = div_reg + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= '0;
            sclk_reg <= 1'b0;
            slot_reg <= '0;
            los_reg  <= 1'b0;
            mark_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            sclk_reg <= sclk_next;
            slot_reg <= slot_next;
            los_reg  <= los_next;
            mark_reg <= mark_next;
        end
    end

    assign status_clock_out             = sclk_reg;
    assign serial_line_signal_loss      = los_reg;
    assign serial_line_signal_loss_oe   = stat_en;
    assign first_channel_slot_marker    = mark_reg;
    assign first_channel_slot_marker_oe = stat_en;

endmodule

// ---- lineif_pkg.sv ----
// Package of constants and register map for the line interface pins
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package lineif_pkg;

    localparam int NCH = 17;
    localparam int CW  = 5;

    // Receive and transmit interface modes
    localparam logic [1:0] MODE_SR_NRZ = 2'h0;
    localparam logic [1:0] MODE_DR_NRZ = 2'h1;
    localparam logic [1:0] MODE_DR_RZ  = 2'h2;
    localparam logic [1:0] MODE_SLICED = 2'h3;

    // Register byte addresses
    localparam logic [11:0] RX_CFG_A_ADDR  = 12'h000;
    localparam logic [11:0] RX_CFG_B_ADDR  = 12'h004;
    localparam logic [11:0] TX_CFG_B_ADDR  = 12'h008;
    localparam logic [11:0] STAT_CFG_ADDR  = 12'h00C;
    localparam logic [11:0] LOS_STAT_ADDR  = 12'h010;
    localparam logic [11:0] INT_STAT_ADDR  = 12'h014;
    localparam logic [11:0] INT_MASK_ADDR  = 12'h018;

    // Field positions
    localparam int RX_LOSS_BEHAV_BIT = 7;
    localparam int RX_EDGE_SEL_BIT   = 4;
    localparam int TX_INVERT_BIT     = 3;
    localparam int MODE_LSB          = 0;
    localparam int STAT_EN_BIT       = 0;
    localparam int STAT_RATE_BIT     = 1;
    localparam int E1_BIT            = 2;

    // Reset values
    localparam logic [7:0] RX_CFG_A_RST = 8'h00;
    localparam logic [7:0] RX_CFG_B_RST = 8'h00;
    localparam logic [7:0] TX_CFG_B_RST = 8'h00;
    localparam logic [7:0] STAT_CFG_RST = 8'h00;

    // Status clock timing: half periods in pclk cycles
    localparam int PCLK_HZ       = 20_000_000;
    localparam int STAT_FAST_HZ  = 2_048_000;
    localparam int STAT_SLOW_HZ  = 8_000;
    localparam int FAST_HALF_INT = PCLK_HZ / (2 * STAT_FAST_HZ);
    localparam int SLOW_HALF_INT = PCLK_HZ / (2 * STAT_SLOW_HZ);
    localparam logic [11:0] FAST_HALF = 12'(FAST_HALF_INT);
    localparam logic [11:0] SLOW_HALF = 12'(SLOW_HALF_INT);
    localparam logic [CW-1:0] LAST_SLOT = CW'(NCH - 1);

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

// ---- lineif_pins_properties.sv ----
// Concurrent checks on the line interface pin behaviour
`timescale 1ns/1ns
module lineif_pins_properties
    import lineif_pkg::*;
(
    input wire logic           pclk,
    input wire logic           presetn,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [11:0]    paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [NCH-1:0] line_clock,
    input wire logic [NCH-1:0] line_loss,
    input wire logic [NCH-1:0] rx_mf_in,
    input wire logic           reference_clock,
    input wire logic [NCH-1:0] recovered_rx_clock,
    input wire logic           status_clock_out,
    input wire logic           serial_line_signal_loss,
    input wire logic           serial_line_signal_loss_oe,
    input wire logic           first_channel_slot_marker,
    input wire logic           first_channel_slot_marker_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------------------------------------------
    // Shadow of mode bits and status clock rise counter
    // ------------------------------------------------------------------
    logic [1:0]     mode_reg;
    logic           behav_reg;
    logic           sc_reg;
    logic           seen_reg;
    logic [4:0]     cnt_reg;
    wire            wr = psel & penable & pwrite;
    wire            srise = status_clock_out & ~sc_reg;
    wire  [NCH-1:0] sub = behav_reg ? {NCH{reference_clock}} : {NCH{1'b1}};
    wire  [NCH-1:0] clk_exp = (line_clock & ~line_loss) | (line_loss & sub);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg <= MODE_SR_NRZ;
            behav_reg <= 1'b0;
            sc_reg <= 1'b0;
            seen_reg <= 1'b0;
            cnt_reg <= 5'h00;
        end else begin
            sc_reg <= status_clock_out;
            if (wr && paddr == RX_CFG_B_ADDR)
                mode_reg <= pwdata[1:0];
            if (wr && paddr == RX_CFG_A_ADDR)
                behav_reg <= pwdata[RX_LOSS_BEHAV_BIT];
            if (!first_channel_slot_marker_oe)
                seen_reg <= 1'b0;
            else if (srise && first_channel_slot_marker)
                seen_reg <= 1'b1;
            if (srise)
                cnt_reg <= first_channel_slot_marker ? 5'h01 : cnt_reg + 5'h01;
        end
    end
    sequence s_srise;
        $rose(status_clock_out);
    endsequence
    property p_oe_pair;
        serial_line_signal_loss_oe == first_channel_slot_marker_oe;
    endproperty
    property p_los_edge;
        serial_line_signal_loss_oe && $past(serial_line_signal_loss_oe)
            && $changed(serial_line_signal_loss) |-> s_srise;
    endproperty
    property p_mark_edge;
        first_channel_slot_marker_oe && $past(first_channel_slot_marker_oe)
            && $changed(first_channel_slot_marker) |-> s_srise;
    endproperty
    property p_mark_width;
        s_srise ##0 ($past(first_channel_slot_marker)
            && $past(first_channel_slot_marker_oe)) |-> !first_channel_slot_marker;
    endproperty
    property p_mark_period;
        srise && first_channel_slot_marker && seen_reg |-> cnt_reg == 5'h11;
    endproperty
    property p_rx_plain;
        mode_reg != MODE_SLICED && line_loss == '0
            |-> recovered_rx_clock == line_clock;
    endproperty
    property p_rx_loss;
        mode_reg != MODE_SLICED |-> recovered_rx_clock == clk_exp;
    endproperty
    property p_rx_sliced;
        mode_reg == MODE_SLICED |-> recovered_rx_clock == rx_mf_in;
    endproperty
    a_oe_pair: assert property (p_oe_pair)
        else $error("enables differ");
    a_los_edge: assert property (p_los_edge)
        else $error("loss changed off the rise");
    a_mark_edge: assert property (p_mark_edge)
        else $error("marker changed off the rise");
    a_mark_width: assert property (p_mark_width)
        else $error("marker longer than one slot");
    a_mark_period: assert property (p_mark_period)
        else $error("marker period wrong");
    a_rx_plain: assert property (p_rx_plain)
        else $error("recovered clock wrong");
    a_rx_loss: assert property (p_rx_loss)
        else $error("loss clock wrong");
    a_rx_sliced: assert property (p_rx_sliced)
        else $error("sliced pin wrong");
endmodule
bind lineif_pins lineif_pins_properties i_lineif_pins_properties (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .line_clock,
    .line_loss, .rx_mf_in, .reference_clock, .recovered_rx_clock,
    .status_clock_out, .serial_line_signal_loss, .serial_line_signal_loss_oe,
    .first_channel_slot_marker, .first_channel_slot_marker_oe);

// ---- framer_model.sv ----
// Framer model driving the transmit side pins
`timescale 1ns/1ns
module framer_model
    import lineif_pkg::*;
(
    input  wire logic           run,
    input  wire logic [NCH-1:0] pos_pat,
    input  wire logic [NCH-1:0] neg_pat,
    output logic      [NCH-1:0] tx_clock_in,
    output logic      [NCH-1:0] tx_positive_rail_data = '0,
    output logic      [NCH-1:0] tx_negative_rail_data = '0
);
    logic clk_q = 1'b0;
    // Clock stands still low outside traffic
    always #244 clk_q = run ? ~clk_q : 1'b0;
    assign tx_clock_in = {NCH{clk_q}};
    // Launch on the fall, stable across the sampling rise
    always @(negedge clk_q) begin
        tx_positive_rail_data <= pos_pat;
        tx_negative_rail_data <= neg_pat;
    end
endmodule

// ---- lineif_pins_bench.sv ----
// Self-checking bench for the line interface pin logic
`timescale 1ns/1ns
module lineif_pins_bench;
    import lineif_pkg::*;
    logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic           refclk = 0, run = 0;
    logic [11:0]    paddr = '0;
    logic [31:0]    pwdata = '0, prdata, rd;
    logic           pready, pslverr, irq, status_clock_out;
    logic           los, los_oe, mk, mk_oe;
    logic [NCH-1:0] line_clock = '0, line_loss = '0, mf = '0, pat = '0;
    logic [NCH-1:0] rec, txc, txp, txn, tps, tns, rxp, rxn;
    int             failures = 0, total_checks = 0;
    localparam logic [NCH-1:0] LOSP = 17'h1A5C3;
    always #25 pclk = ~pclk;
    lineif_pins i_lineif_pins (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .line_clock,
        .line_loss, .rx_pos_in(mf), .rx_neg_in(~mf), .rx_mf_in(mf),
        .reference_clock(refclk), .recovered_rx_clock(rec),
        .rx_positive_rail_data(rxp), .rx_negative_rail_data(rxn),
        .status_clock_out,
        .serial_line_signal_loss(los), .serial_line_signal_loss_oe(los_oe),
        .first_channel_slot_marker(mk), .first_channel_slot_marker_oe(mk_oe),
        .tx_clock_in(txc), .tx_positive_rail_data(txp),
        .tx_negative_rail_data(txn), .tx_pos_sampled(tps),
        .tx_neg_sampled(tns));
    framer_model i_framer_model (.run, .pos_pat(pat), .neg_pat(~pat),
        .tx_clock_in(txc), .tx_positive_rail_data(txp),
        .tx_negative_rail_data(txn));
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 50)
            failures++;
        rd = prdata;
        chk(32'(pslverr), 32'h0);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic test_regs;
        logic [11:0] a [5] = '{RX_CFG_A_ADDR, RX_CFG_B_ADDR, TX_CFG_B_ADDR,
                               STAT_CFG_ADDR, 12'h01C};
        apb(1, 12'h01C, 32'hFFFF_FFFF);
        foreach (a[i]) begin
            apb(0, a[i], 32'h0);
            chk(rd, 32'h0);
        end
        $display("register test done");
    endtask
    task automatic test_mux;
        line_clock <= 17'h0F0F0;
        mf <= 17'h13579;
        for (int m = 0; m < 3; m++) begin
            apb(1, RX_CFG_B_ADDR, 32'(m));
            @(negedge pclk);
            chk(32'(rec), 32'h0F0F0);
        end
        apb(1, RX_CFG_A_ADDR, 32'h0);
        line_loss <= 17'h00003;
        @(negedge pclk);
        chk(32'(rec), 32'h0F0F3);
        apb(1, RX_CFG_A_ADDR, 32'h80);
        @(negedge pclk);
        chk(32'(rec), 32'h0F0F0);
        apb(1, RX_CFG_B_ADDR, 32'(MODE_SLICED));
        @(negedge pclk);
        chk(32'(rec), 32'h13579);
        apb(1, RX_CFG_B_ADDR, 32'h0);
        line_loss <= '0;
        $display("clock mux test done");
    endtask
    task automatic test_irq;
        apb(1, INT_STAT_ADDR, 32'h1FFFF);
        line_loss <= LOSP;
        repeat (4) @(posedge pclk);
        apb(0, LOS_STAT_ADDR, 32'h0);
        chk(rd, 32'(LOSP));
        apb(0, INT_STAT_ADDR, 32'h0);
        chk(rd, 32'(LOSP));
        chk(32'(irq), 32'h0);
        apb(1, INT_MASK_ADDR, 32'h40);
        @(negedge pclk);
        chk(32'(irq), 32'h1);
        apb(1, INT_STAT_ADDR, 32'h40);
        @(negedge pclk);
        chk(32'(irq), 32'h0);
        apb(0, INT_STAT_ADDR, 32'h0);
        chk(rd, 32'h1A583);
        $display("interrupt test done");
    endtask
    task automatic test_rx;
        line_clock <= '0;
        mf <= 17'h0AAAA;
        apb(1, RX_CFG_B_ADDR, 32'(MODE_DR_NRZ));
        @(posedge pclk);
        line_clock <= '1;
        @(negedge pclk);
        chk(32'(rxp), 32'h0AAAA);
        chk(32'(rxn), 32'h15555);
        mf <= 17'h15555;
        line_clock <= '0;
        @(negedge pclk);
        chk(32'(rxp), 32'h0AAAA);
        apb(1, RX_CFG_B_ADDR, 32'h11);
        @(negedge pclk);
        chk(32'(rxp), 32'h15555);
        mf <= 17'h0AAAA;
        @(posedge pclk);
        line_clock <= '1;
        @(negedge pclk);
        chk(32'(rxp), 32'h15555);
        line_clock <= '0;
        @(negedge pclk);
        chk(32'(rxp), 32'h0AAAA);
        apb(1, RX_CFG_B_ADDR, 32'h0);
        $display("receive data test done");
    endtask
    task automatic test_frame(input logic [31:0] cfg, input int n);
        int slot;
        slot = -1;
        apb(1, STAT_CFG_ADDR, cfg);
        repeat (n) begin
            @(negedge status_clock_out);
            if (slot < 0 && mk === 1'b1)
                slot = 0;
            if (slot >= 0) begin
                chk(32'(los), 32'(LOSP[slot]));
                chk(32'(mk), 32'(slot == 0));
                slot = (slot + 1) % NCH;
            end
        end
        chk(32'(slot >= 0 && los_oe && mk_oe), 32'h1);
        apb(1, STAT_CFG_ADDR, 32'h0);
        @(negedge pclk);
        chk(32'({los_oe, mk_oe}), 32'h0);
        $display("serial frame test done");
    endtask
    task automatic tx_case(input logic [31:0] cfg, input logic [NCH-1:0] p,
                           input logic [NCH-1:0] q);
        apb(1, TX_CFG_B_ADDR, cfg);
        repeat (40) @(posedge pclk);
        chk(32'(tps), 32'(p));
        chk(32'(tns), 32'(q));
    endtask
    task automatic test_tx;
        pat <= 17'h15A5A;
        run <= 1;
        tx_case(32'(MODE_DR_NRZ), 17'h15A5A, 17'h0A5A5);
        tx_case(32'h0A, 17'h0A5A5, 17'h15A5A);
        tx_case(32'(MODE_SR_NRZ), 17'h15A5A, 17'h0);
        run <= 0;
        $display("transmit test done");
    endtask
    initial begin
        #4_000_000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        test_regs();
        test_mux();
        test_irq();
        test_rx();
        test_frame(32'h3, 40);
        test_frame(32'h1, 20);
        test_tx();
        end_of_test();
    end
endmodule
